// >>> design/scx_pkg.sv
// Constants, register map and field layout of the system control exception registers.
// Function
// - Non-reset exceptions jump to vector base plus region and cache bits plus 12-bit offset.
// - Translation and address error faults load the faulting virtual address; software may write.
// - Fetch faults on an instruction cache miss capture the cache block start address.
// - A 32-bit readable, writable cycle counter increments every clock.
// - Pending interrupt line 10 follows counter bit 31.
// - Region field codes: user 00, first kernel region 01, second 11.
// - Translation faults load region and page number from bits 47:19; tag unchanged.
// - Page number bits 23:19 are each zeroed according to page size.
// - Interrupts are globally enabled only with enable 1 and exception level 0.
// - User mode only with mode bit 1 and exception level 0, else kernel.
// - User mode gates extension and legacy opcodes by their enables; kernel allows all.
// - A maskable interrupt is taken when enabled, masked in and pending.
// - Kernel byte order from config bit; user mode inverts it when flip set.
// - Register bank bit selects 16 registers at 0, 32 at 1.
// - Unusable coprocessor raises an exception; coprocessor zero always usable in kernel.
// - Page size codes 0000 to 0110 map 4K to 16M; others reserved.
// - Floating mode bit selects performance at 0, precise exceptions at 1.
// - Processor state register takes defined values at reset.
// - Floating interrupt flag is AND of unit enables and flags.
// - Coherence faults set the coherence flag; software clears it.
// - Tag bus sets bus error and nmi flags; software cannot alter bus error.
// - Exception codes 0 to 5 and 8 to 12 as tabled.
// - Trap reports code 13; codes 14 to 31 never used.
package scx_pkg;

  // Register indices; byte address is four times the index, upper halves selected by address bit HI_BIT.
  localparam logic [5:0] IDX_UPTB  = 6'h04;
  localparam logic [5:0] IDX_SHAMT = 6'h05;
  localparam logic [5:0] IDX_VBASE = 6'h06;
  localparam logic [5:0] IDX_BPA   = 6'h07;
  localparam logic [5:0] IDX_FVA   = 6'h08;
  localparam logic [5:0] IDX_CNT   = 6'h09;
  localparam logic [5:0] IDX_EHI   = 6'h0A;
  localparam logic [5:0] IDX_PS    = 6'h0C;
  localparam logic [5:0] IDX_CAUSE = 6'h0D;
  localparam logic [5:0] IDX_CFG   = 6'h10;
  localparam int         HI_BIT    = 8;

  // Processor state fields.
  localparam int PS_IE  = 0;
  localparam int PS_EXL = 1;
  localparam int PS_KU  = 4;
  localparam int PS_UX  = 5;
  localparam int PS_XX  = 6;
  localparam int PS_IM  = 8;
  localparam int PS_RE  = 25;
  localparam int PS_FR  = 26;
  localparam int PS_CU  = 28;
  localparam int PS_UPS = 32;
  localparam int PS_KPS = 36;
  localparam int PS_DM  = 40;
  localparam logic [63:0] PS_RST   = 64'h0000_0000_0000_0002;
  localparam logic [63:0] PS_WMASK = 64'h0000_01FF_3607_FF73;

  // Upper translation entry and vector base layouts.
  localparam int          EHI_REG   = 62;
  localparam int          EHI_VPN   = 19;
  localparam logic [63:0] EHI_WMASK = 64'hC000_FFFF_FFF8_00FF;
  localparam logic [63:0] VB_WMASK  = 64'hC700_FFFF_FFFF_F000;
  localparam logic [1:0]  RGN_USER  = 2'h0;
  localparam logic [1:0]  RGN_KV0   = 2'h1;
  localparam logic [1:0]  RGN_KV1   = 2'h3;
  localparam int          ICB_LOG2  = 6;

  // Exception reason fields.
  localparam int          CA_CODE  = 2;
  localparam int          CA_IP    = 8;
  localparam int          CA_IRQ_PENDING_10  = 18;
  localparam int          CA_FPI   = 24;
  localparam int          CA_VCI   = 25;
  localparam int          CA_BE    = 26;
  localparam int          CA_NMI   = 27;
  localparam logic [31:0] CA_SWMASK = 32'h0A00_0000;

  // Page size codes; pg_shift gives their shift amounts.
  localparam logic [3:0] PG_4K   = 4'h0;
  localparam logic [3:0] PG_8K   = 4'h1;
  localparam logic [3:0] PG_16K  = 4'h2;
  localparam logic [3:0] PG_64K  = 4'h3;
  localparam logic [3:0] PG_1M   = 4'h4;
  localparam logic [3:0] PG_4M   = 4'h5;
  localparam logic [3:0] PG_16M  = 4'h6;

  // Exception codes.
  localparam logic [4:0] EXC_INT  = 5'h00;
  localparam logic [4:0] EXC_MOD  = 5'h01;
  localparam logic [4:0] EXC_TLBL = 5'h02;
  localparam logic [4:0] EXC_TLBS = 5'h03;
  localparam logic [4:0] EXC_ADEL = 5'h04;
  localparam logic [4:0] EXC_ADES = 5'h05;
  localparam logic [4:0] EXC_SYS  = 5'h08;
  localparam logic [4:0] EXC_BP   = 5'h09;
  localparam logic [4:0] EXC_RI   = 5'h0A;
  localparam logic [4:0] EXC_CPU  = 5'h0B;
  localparam logic [4:0] EXC_OV   = 5'h0C;
  localparam logic [4:0] EXC_TR   = 5'h0D;

endpackage

// >>> design/scx_regs.sv
// System control exception registers with an AHB-Lite register slave.
//
// Register access over AHB-Lite was chosen for this implementation.
module scx_regs
  import scx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        exc_valid,
  input  wire logic [4:0]  exc_code,
  input  wire logic [63:0] exc_fault_virtual_address,
  input  wire logic        exc_is_tlb,
  input  wire logic        exc_is_addr,
  input  wire logic        exc_ifetch_miss,
  input  wire logic [11:0] exc_vec_offset,
  input  wire logic [9:0]  irq_lines,
  input  wire logic [4:0]  fp_enables,
  input  wire logic [4:0]  fp_flags,
  input  wire logic        vce_set,
  input  wire logic [63:0] vce_paddr,
  input  wire logic        system_tag_bus_be_set,
  input  wire logic        system_tag_bus_be_clr,
  input  wire logic        system_tag_bus_nmi_set,
  input  wire logic        cop_req_valid,
  input  wire logic        cop_req_num,
  output logic      [63:0] new_pc,
  output logic             new_pc_valid,
  output logic             irq_take,
  output logic             nmi_req,
  output logic             glb_irq_en,
  output logic             user_mode,
  output logic             ext_ops_ok,
  output logic             legacy_ops_ok,
  output logic             big_endian,
  output logic             fp_regs_32,
  output logic             fp_precise,
  output logic      [1:0]  cop_usable,
  output logic             cop_unusable
);

  typedef struct packed {
    logic [63:0] uptb;
    logic [5:0]  shamt;
    logic [63:0] vbase;
    logic [63:0] bpa;
    logic [63:0] fva;
    logic [31:0] cnt;
    logic [63:0] ehi;
    logic [63:0] ps;
    logic [31:0] cause;
    logic        cfg_be;
    logic        nmi_hw;
    logic        wr_pend;
    logic [5:0]  wr_idx;
    logic        wr_hi;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [63:0] new_pc;
    logic        new_pc_valid;
    logic        irq_take;
    logic        glb_irq_en;
    logic        user_mode;
    logic        ext_ops_ok;
    logic        legacy_ops_ok;
    logic        big_endian;
    logic [1:0]  cop_usable;
    logic        cop_unusable;
  } scx_state_t;

  // Reset leaves the core in kernel mode, so the opcode and coprocessor zero permissions start granted.
  localparam scx_state_t ST_RST = '{ps: PS_RST, hreadyout: 1'b1, ext_ops_ok: 1'b1,
                                    legacy_ops_ok: 1'b1, cop_usable: 2'h1,
                                    default: '0};

  scx_state_t st_reg;
  scx_state_t st_next;

  // Shift amount of a page size code; reserved codes fall back to the smallest page.
  function automatic logic [5:0] pg_shift(input logic [3:0] code);
    logic [5:0] s;
    s = 6'h0C;
    unique case (code)
      PG_4K:   s = 6'h0C;
      PG_8K:   s = 6'h0D;
      PG_16K:  s = 6'h0E;
      PG_64K:  s = 6'h10;
      PG_1M:   s = 6'h14;
      PG_4M:   s = 6'h16;
      PG_16M:  s = 6'h18;
      default: s = 6'h0C;
    endcase
    return s;
  endfunction

  // Codes outside the table are reported as reserved instruction.
  function automatic logic [4:0] legal_code(input logic [4:0] c);
    logic [4:0] r;
    r = c;
    if ((c == 5'h06) || (c == 5'h07) || (c > EXC_TR)) begin
      r = EXC_RI;
    end
    return r;
  endfunction

  function automatic logic [63:0] put_half(input logic [63:0] o, input logic hi,
                                           input logic [31:0] d, input logic [63:0] m);
    logic [63:0] v;
    v = hi ? {d, o[31:0]} : {o[63:32], d};
    return (v & m) | (o & ~m);
  endfunction

  logic [5:0] fault_shift;
  logic [4:0] vpn_keep;
  logic [1:0] fault_rgn;

  assign fault_rgn   = exc_fault_virtual_address[63:62];
  assign fault_shift = (fault_rgn == RGN_USER) ? pg_shift(st_reg.ps[PS_UPS+:4])
                                               : pg_shift(st_reg.ps[PS_KPS+:4]);

  for (genvar b = 0; b < 5; b++) begin : g_vpn
    assign vpn_keep[b] = (fault_shift <= 6'(EHI_VPN + b));
  end

  logic        a_phase;
  logic [5:0]  a_idx;
  logic        a_hi;
  logic [63:0] rd_full;
  logic [31:0] sw_d;
  logic        sw_we;
  logic [10:0] ip_vec;
  logic        kern;

  assign a_phase = hsel && htrans[1] && hready;
  assign a_idx   = haddr[7:2];
  assign a_hi    = haddr[HI_BIT];
  assign sw_d    = hwdata;

  always_comb begin
    rd_full = 64'h0;
    unique case (a_idx)
      IDX_UPTB:  rd_full = st_reg.uptb;
      IDX_SHAMT: rd_full = {58'h0, st_reg.shamt};
      IDX_VBASE: rd_full = st_reg.vbase;
      IDX_BPA:   rd_full = st_reg.bpa;
      IDX_FVA:   rd_full = st_reg.fva;
      IDX_CNT:   rd_full = {32'h0, st_reg.cnt};
      IDX_EHI:   rd_full = st_reg.ehi;
      IDX_PS:    rd_full = st_reg.ps;
      IDX_CAUSE: rd_full = {32'h0, st_reg.cause};
      IDX_CFG:   rd_full = {63'h0, st_reg.cfg_be};
      default:   rd_full = 64'h0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    sw_we   = st_reg.wr_pend;

    // Bus: address phase captured, write data applied in the data phase.
    st_next.wr_pend   = a_phase && hwrite;
    st_next.wr_idx    = a_idx;
    st_next.wr_hi     = a_hi;
    st_next.hreadyout = 1'b1;
    st_next.hrdata    = (a_phase && !hwrite) ? (a_hi ? rd_full[63:32] : rd_full[31:0])
                                             : 32'h0;

    st_next.cnt = st_reg.cnt + 32'h1;

    if (sw_we) begin
      unique case (st_reg.wr_idx)
        IDX_UPTB:  st_next.uptb  = put_half(st_reg.uptb, st_reg.wr_hi, sw_d, '1);
        IDX_VBASE: st_next.vbase = put_half(st_reg.vbase, st_reg.wr_hi, sw_d, VB_WMASK);
        IDX_FVA:   st_next.fva   = put_half(st_reg.fva, st_reg.wr_hi, sw_d, '1);
        IDX_CNT: begin
          if (!st_reg.wr_hi) begin
            st_next.cnt = sw_d;
          end
        end
        IDX_EHI:   st_next.ehi   = put_half(st_reg.ehi, st_reg.wr_hi, sw_d, EHI_WMASK);
        IDX_PS:    st_next.ps    = put_half(st_reg.ps, st_reg.wr_hi, sw_d, PS_WMASK);
        IDX_CAUSE: begin
          if (!st_reg.wr_hi) begin
            st_next.cause = (sw_d & CA_SWMASK) | (st_reg.cause & ~CA_SWMASK);
            if (!sw_d[CA_NMI]) begin
              st_next.nmi_hw = 1'b0;
            end
          end
        end
        IDX_CFG: begin
          if (!st_reg.wr_hi) begin
            st_next.cfg_be = sw_d[0];
          end
        end
        default: ;
      endcase
    end

    // Hardware events follow software writes so that a set beats a clear.
    if (vce_set) begin
      st_next.cause[CA_VCI] = 1'b1;
      st_next.bpa           = vce_paddr;
    end
    if (system_tag_bus_be_set) begin
      st_next.cause[CA_BE] = 1'b1;
    end else if (system_tag_bus_be_clr) begin
      st_next.cause[CA_BE] = 1'b0;
    end
    if (system_tag_bus_nmi_set) begin
      st_next.cause[CA_NMI] = 1'b1;
      st_next.nmi_hw        = 1'b1;
    end
    st_next.cause[CA_FPI] = |(fp_enables & fp_flags);

    st_next.new_pc_valid = 1'b0;
    if (exc_valid) begin
      st_next.ps[PS_EXL]          = 1'b1;
      st_next.cause[CA_CODE+:5]   = legal_code(exc_code);
      st_next.new_pc              = (st_reg.vbase & VB_WMASK) | {52'h0, exc_vec_offset};
      st_next.new_pc_valid        = 1'b1;
      if (exc_is_tlb || exc_is_addr) begin
        st_next.fva = exc_ifetch_miss ? {exc_fault_virtual_address[63:ICB_LOG2], {ICB_LOG2{1'b0}}}
                                      : exc_fault_virtual_address;
      end
      if (exc_is_tlb) begin
        st_next.ehi[EHI_REG+:2]    = fault_rgn;
        st_next.ehi[47:24]         = exc_fault_virtual_address[47:24];
        st_next.ehi[EHI_VPN+:5]    = exc_fault_virtual_address[EHI_VPN+:5] & vpn_keep;
        st_next.shamt              = fault_shift;
      end
    end

    // Derived outputs except cop_unusable are built from the next state so they match the registers.
    ip_vec                 = {st_next.cnt[31], irq_lines};
    st_next.cause[CA_IP+:11] = ip_vec;
    st_next.glb_irq_en  = st_next.ps[PS_IE] && !st_next.ps[PS_EXL];
    st_next.user_mode   = st_next.ps[PS_KU] && !st_next.ps[PS_EXL];
    kern                = !st_next.user_mode;
    st_next.ext_ops_ok    = kern || st_next.ps[PS_XX];
    st_next.legacy_ops_ok = kern || st_next.ps[PS_UX];
    st_next.irq_take    = st_next.glb_irq_en && |(st_next.ps[PS_IM+:11] & ip_vec);
    st_next.big_endian  = st_next.cfg_be ^ (st_next.user_mode && st_next.ps[PS_RE]);
    st_next.cop_usable  = {st_next.ps[PS_CU+1], st_next.ps[PS_CU] || kern};
    st_next.cop_unusable = cop_req_valid && !st_reg.cop_usable[cop_req_num];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata        = st_reg.hrdata;
  assign hreadyout     = st_reg.hreadyout;
  assign hresp         = 1'b0;
  assign new_pc        = st_reg.new_pc;
  assign new_pc_valid  = st_reg.new_pc_valid;
  assign irq_take      = st_reg.irq_take;
  assign nmi_req       = st_reg.nmi_hw;
  assign glb_irq_en    = st_reg.glb_irq_en;
  assign user_mode     = st_reg.user_mode;
  assign ext_ops_ok    = st_reg.ext_ops_ok;
  assign legacy_ops_ok = st_reg.legacy_ops_ok;
  assign big_endian    = st_reg.big_endian;
  assign fp_regs_32    = st_reg.ps[PS_FR];
  assign fp_precise    = st_reg.ps[PS_DM];
  assign cop_usable    = st_reg.cop_usable;
  assign cop_unusable  = st_reg.cop_unusable;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence tlb_fault_s;
    exc_valid && exc_is_tlb;
  endsequence

  sequence plain_fetch_s;
    exc_valid && (exc_is_tlb || exc_is_addr) && !exc_ifetch_miss;
  endsequence

  cnt_step_a: assert property (!(st_reg.wr_pend && st_reg.wr_idx == IDX_CNT)
                               |=> st_reg.cnt == $past(st_reg.cnt) + 32'h1)
    else $error("cycle counter did not step by one");
  ip_tap_a: assert property (st_reg.cause[CA_IRQ_PENDING_10] == st_reg.cnt[31])
    else $error("pending line 10 differs from counter top bit");
  irq_gate_a: assert property (glb_irq_en == (st_reg.ps[PS_IE] && !st_reg.ps[PS_EXL]))
    else $error("global interrupt enable wrong");
  mode_sel_a: assert property (user_mode == (st_reg.ps[PS_KU] && !st_reg.ps[PS_EXL]))
    else $error("user mode wrong");
  kern_ops_a: assert property (!user_mode |-> ext_ops_ok && legacy_ops_ok)
    else $error("opcodes blocked in kernel mode");
  irq_take_a: assert property (irq_take
                               |-> glb_irq_en && |(st_reg.ps[PS_IM+:11] & st_reg.cause[CA_IP+:11]))
    else $error("interrupt taken without enable, mask and pending");
  byte_order_a: assert property (big_endian
                                 == (st_reg.cfg_be ^ (user_mode && st_reg.ps[PS_RE])))
    else $error("byte order wrong");
  cop0_kern_a: assert property (!user_mode |-> cop_usable[0])
    else $error("coprocessor zero unusable in kernel mode");
  fault_virtual_address_load_a: assert property (plain_fetch_s |=> st_reg.fva == $past(exc_fault_virtual_address))
    else $error("faulting address not captured");
  tag_keep_a: assert property (tlb_fault_s |=> st_reg.ehi[7:0] == $past(st_reg.ehi[7:0])
                               && st_reg.ehi[63:62] == $past(exc_fault_virtual_address[63:62]))
    else $error("translation entry capture wrong");
  vec_form_a: assert property (exc_valid |=> new_pc_valid
                               && new_pc[11:0] == $past(exc_vec_offset))
    else $error("vector address not formed");
  be_hold_a: assert property (!system_tag_bus_be_set && !system_tag_bus_be_clr
                              |=> $stable(st_reg.cause[CA_BE]))
    else $error("bus error flag changed without tag bus");
  vci_set_a: assert property (vce_set |=> st_reg.cause[CA_VCI])
    else $error("coherence flag not set");
  ro_keep_a: assert property (st_reg.wr_pend && st_reg.wr_idx == IDX_SHAMT && !exc_valid
                              |=> $stable(st_reg.shamt))
    else $error("read-only register changed by write");
  code_rng_a: assert property (st_reg.cause[CA_CODE+:5] <= EXC_TR)
    else $error("unused exception code reported");

endmodule

// >>> sim/scx_pipe_model.sv
// Behavioural model of the pipeline and tag bus side of the exception registers.
module scx_pipe_model (
  input  wire logic        clk,
  output logic             exc_valid,
  output logic      [4:0]  exc_code,
  output logic      [63:0] exc_fault_virtual_address,
  output logic             exc_is_tlb,
  output logic             exc_is_addr,
  output logic             exc_ifetch_miss,
  output logic      [11:0] exc_vec_offset,
  output logic      [9:0]  irq_lines,
  output logic      [4:0]  fp_enables,
  output logic      [4:0]  fp_flags,
  output logic             vce_set,
  output logic      [63:0] vce_paddr,
  output logic             system_tag_bus_be_set,
  output logic             system_tag_bus_be_clr,
  output logic             system_tag_bus_nmi_set,
  output logic             cop_req_valid,
  output logic             cop_req_num
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {exc_valid, exc_code, exc_fault_virtual_address, exc_is_tlb, exc_is_addr, exc_ifetch_miss} = '0;
    {exc_vec_offset, irq_lines, fp_enables, fp_flags, vce_set, vce_paddr} = '0;
    {system_tag_bus_be_set, system_tag_bus_be_clr, system_tag_bus_nmi_set, cop_req_valid, cop_req_num} = '0;
  end

  // Qualifiers stand only with the pulse; data lines are scrambled afterwards.
  task automatic exc(input logic [4:0] c, input logic [63:0] va, input logic t, a, m,
                     input logic [11:0] off);
    @(posedge clk);
    exc_valid <= 1'b1;
    exc_code <= c;
    exc_fault_virtual_address <= va;
    exc_is_tlb <= t;
    exc_is_addr <= a;
    exc_ifetch_miss <= m;
    exc_vec_offset <= off;
    @(posedge clk);
    {exc_valid, exc_is_tlb, exc_is_addr, exc_ifetch_miss} <= 4'h0;
    exc_code <= ~c;
    exc_fault_virtual_address <= ~va;
    exc_vec_offset <= ~off;
  endtask

  task automatic levels(input logic [9:0] irq, input logic [4:0] en, fl);
    @(posedge clk);
    irq_lines <= irq;
    fp_enables <= en;
    fp_flags <= fl;
  endtask

  task automatic vce(input logic [63:0] pa);
    @(posedge clk);
    vce_set <= 1'b1;
    vce_paddr <= pa;
    @(posedge clk);
    vce_set <= 1'b0;
    vce_paddr <= ~pa;
  endtask

  // Selects 0 set bus error, 1 clear bus error, 2 non-maskable interrupt.
  task automatic system_tag_bus(input int sel);
    @(posedge clk);
    {system_tag_bus_nmi_set, system_tag_bus_be_clr, system_tag_bus_be_set} <= 3'h1 << sel;
    @(posedge clk);
    {system_tag_bus_nmi_set, system_tag_bus_be_clr, system_tag_bus_be_set} <= 3'h0;
  endtask

  task automatic cop(input logic n);
    @(posedge clk);
    cop_req_valid <= 1'b1;
    cop_req_num <= n;
    @(posedge clk);
    cop_req_valid <= 1'b0;
    cop_req_num <= ~n;
  endtask
endmodule

// >>> sim/scx_regs_tb.sv
// Self-checking testbench of the exception registers over AHB-Lite.
module scx_regs_tb
  import scx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v, a;
  logic [1:0]  htrans = 2'h0, cop_usable;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  exc_code, fp_enables, fp_flags, cd;
  logic [63:0] exc_fault_virtual_address, vce_paddr, new_pc, w;
  logic [11:0] exc_vec_offset;
  logic [9:0]  irq_lines;
  logic        hreadyout, hresp, exc_valid, exc_is_tlb, exc_is_addr, exc_ifetch_miss;
  logic        vce_set, system_tag_bus_be_set, system_tag_bus_be_clr, system_tag_bus_nmi_set, cop_req_valid, cop_req_num;
  logic        new_pc_valid, irq_take, nmi_req, glb_irq_en, user_mode, ext_ops_ok;
  logic        legacy_ops_ok, big_endian, fp_regs_32, fp_precise, cop_unusable;
  int          n_errors = 0, n_tests = 0;
  logic [31:0] ps_lo [5] = '{32'h2000_0051, 32'h0600_0033, 32'h1200_0031, 32'h1200_0031,
                             32'h0600_0033};
  logic [31:0] ps_hi [5] = '{32'h0000_0100, 32'h0, 32'h0, 32'h0, 32'h0};
  logic        cfg   [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [8:0]  mexp  [5] = '{9'h1C6, 9'h069, 9'h1B1, 9'h1A1, 9'h079};

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  scx_regs scx_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exc_valid(exc_valid),
    .exc_code(exc_code), .exc_fault_virtual_address(exc_fault_virtual_address), .exc_is_tlb(exc_is_tlb),
    .exc_is_addr(exc_is_addr), .exc_ifetch_miss(exc_ifetch_miss),
    .exc_vec_offset(exc_vec_offset), .irq_lines(irq_lines), .fp_enables(fp_enables),
    .fp_flags(fp_flags), .vce_set(vce_set), .vce_paddr(vce_paddr), .system_tag_bus_be_set(system_tag_bus_be_set),
    .system_tag_bus_be_clr(system_tag_bus_be_clr), .system_tag_bus_nmi_set(system_tag_bus_nmi_set), .cop_req_valid(cop_req_valid),
    .cop_req_num(cop_req_num), .new_pc(new_pc), .new_pc_valid(new_pc_valid),
    .irq_take(irq_take), .nmi_req(nmi_req), .glb_irq_en(glb_irq_en), .user_mode(user_mode),
    .ext_ops_ok(ext_ops_ok), .legacy_ops_ok(legacy_ops_ok), .big_endian(big_endian),
    .fp_regs_32(fp_regs_32), .fp_precise(fp_precise), .cop_usable(cop_usable),
    .cop_unusable(cop_unusable));

  scx_pipe_model scx_pipe_model_i (.clk(hclk), .exc_valid(exc_valid), .exc_code(exc_code),
    .exc_fault_virtual_address(exc_fault_virtual_address), .exc_is_tlb(exc_is_tlb), .exc_is_addr(exc_is_addr),
    .exc_ifetch_miss(exc_ifetch_miss), .exc_vec_offset(exc_vec_offset),
    .irq_lines(irq_lines), .fp_enables(fp_enables), .fp_flags(fp_flags), .vce_set(vce_set),
    .vce_paddr(vce_paddr), .system_tag_bus_be_set(system_tag_bus_be_set), .system_tag_bus_be_clr(system_tag_bus_be_clr),
    .system_tag_bus_nmi_set(system_tag_bus_nmi_set), .cop_req_valid(cop_req_valid), .cop_req_num(cop_req_num));

  // Upper halves of 64-bit registers sit in the window above the low words.
  function automatic logic [31:0] ad(input logic [5:0] i, input logic h);
    return {23'h0, h, i, 2'h0};
  endfunction

  task automatic xfer(input logic [31:0] ar, input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ar;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] ar, input logic [31:0] d);
    logic [31:0] q;
    xfer(ar, 1'b1, d, q);
  endtask

  task automatic rd(input logic [31:0] ar, output logic [31:0] q);
    xfer(ar, 1'b0, 32'h0, q);
  endtask

  task automatic rd64(input logic [5:0] i, output logic [63:0] q);
    rd(ad(i, 1'b0), q[31:0]);
    rd(ad(i, 1'b1), q[63:32]);
  endtask

  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ad(IDX_PS, 1'b0), v);
    chk("ps_reset", v, 64'h2);
    chk("reset_mode", {glb_irq_en, user_mode, ext_ops_ok, legacy_ops_ok, cop_usable}, 64'hD);
    chk("bus_resp", {hreadyout, hresp}, 64'h2);
    rd(ad(6'h02, 1'b0), v);
    chk("unmapped", v, 64'h0);
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("tap_low", v[18], 64'h0);
    wr(ad(IDX_CNT, 1'b0), 32'h7FFF_FFF8);
    rd(ad(IDX_CNT, 1'b0), a);
    rd(ad(IDX_CNT, 1'b0), v);
    chk("cnt_step", v - a, 64'h3);
    repeat (8) @(posedge hclk);
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("tap_high", v[18], 64'h1);
    for (int i = 0; i < 5; i++) begin
      wr(ad(IDX_CFG, 1'b0), {31'h0, cfg[i]});
      wr(ad(IDX_PS, 1'b1), ps_hi[i]);
      wr(ad(IDX_PS, 1'b0), ps_lo[i]);
      settle();
      chk("mode", {glb_irq_en, user_mode, ext_ops_ok, legacy_ops_ok, big_endian, fp_regs_32,
                   fp_precise, cop_usable}, mexp[i]);
      for (int n = 0; n < 2; n++) begin
        scx_pipe_model_i.cop(n[0]);
        #1;
        chk("cop_unusable", cop_unusable, !mexp[i][n]);
      end
    end
    wr(ad(IDX_PS, 1'b1), 32'h0);
    wr(ad(IDX_PS, 1'b0), 32'h0000_0101);
    scx_pipe_model_i.levels(10'h001, 5'h04, 5'h06);
    settle();
    chk("irq_on", {glb_irq_en, irq_take}, 64'h3);
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("fp_pend", {v[24], v[8]}, 64'h3);
    wr(ad(IDX_PS, 1'b0), 32'h0000_0001);
    scx_pipe_model_i.levels(10'h001, 5'h04, 5'h02);
    settle();
    chk("irq_masked", irq_take, 64'h0);
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("fp_off", v[24], 64'h0);
    wr(ad(IDX_VBASE, 1'b0), 32'h0000_5000);
    wr(ad(IDX_VBASE, 1'b1), 32'h0000_0012);
    wr(ad(IDX_PS, 1'b1), {28'h0, PG_1M});
    wr(ad(IDX_EHI, 1'b0), 32'h0000_00A5);
    scx_pipe_model_i.exc(EXC_TLBL, 64'h0000_1234_5678_9ABC, 1'b1, 1'b0, 1'b0, 12'h180);
    #1;
    chk("pc_valid", new_pc_valid, 64'h1);
    chk("new_pc", new_pc, 64'h0000_0012_0000_5180);
    chk("level_off", glb_irq_en, 64'h0);
    rd64(IDX_FVA, w);
    chk("fva", w, 64'h0000_1234_5678_9ABC);
    rd64(IDX_EHI, w);
    chk("upper_user", w, 64'h0000_1234_5670_00A5);
    rd(ad(IDX_SHAMT, 1'b0), v);
    chk("shift_1m", v, 64'h14);
    scx_pipe_model_i.exc(EXC_TLBS, 64'hC000_0000_00F8_0000, 1'b1, 1'b0, 1'b0, 12'h000);
    rd64(IDX_EHI, w);
    chk("upper_kv1", w, 64'hC000_0000_00F8_00A5);
    wr(ad(IDX_PS, 1'b1), {24'h0, PG_16M, PG_1M});
    scx_pipe_model_i.exc(EXC_MOD, 64'h4000_0000_00F8_0000, 1'b1, 1'b0, 1'b0, 12'h000);
    rd64(IDX_EHI, w);
    chk("upper_kv0", w, 64'h4000_0000_0000_00A5);
    scx_pipe_model_i.exc(EXC_ADEL, 64'h0000_0000_0040_107F, 1'b0, 1'b1, 1'b1, 12'h080);
    rd64(IDX_FVA, w);
    chk("fva_block", w, 64'h0000_0000_0040_1040);
    for (int c = 0; c < 17; c++) begin
      cd = (c == 16) ? 5'h1F : c[4:0];
      scx_pipe_model_i.exc(cd, 64'h0, 1'b0, 1'b0, 1'b0, 12'h000);
      rd(ad(IDX_CAUSE, 1'b0), v);
      chk("exc_code", v[6:2], (cd inside {5'h06, 5'h07} || cd > 5'h0D) ? 5'h0A : cd);
    end
    scx_pipe_model_i.vce(64'h0000_00AB_CDEF_1000);
    scx_pipe_model_i.system_tag_bus(0);
    scx_pipe_model_i.system_tag_bus(2);
    settle();
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("flags_set", v[27:25], 64'h7);
    chk("nmi_req", nmi_req, 64'h1);
    rd64(IDX_BPA, w);
    chk("bad_pa", w, 64'h0000_00AB_CDEF_1000);
    wr(ad(IDX_CAUSE, 1'b0), 32'h0);
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("flags_sw", v[27:25], 64'h2);
    chk("nmi_clr", nmi_req, 64'h0);
    scx_pipe_model_i.system_tag_bus(1);
    rd(ad(IDX_CAUSE, 1'b0), v);
    chk("bus_clr", v[26], 64'h0);
    wr(ad(IDX_BPA, 1'b0), 32'hFFFF_FFFF);
    wr(ad(IDX_SHAMT, 1'b0), 32'h0);
    rd(ad(IDX_BPA, 1'b0), v);
    chk("bpa_ro", v, 64'hCDEF_1000);
    rd(ad(IDX_SHAMT, 1'b0), v);
    chk("shamt_ro", v, 64'h18);
    hresetn <= 1'b0;
    #1;
    chk("rst_out", {ext_ops_ok, legacy_ops_ok, cop_usable, nmi_req}, 64'h1A);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ad(IDX_PS, 1'b0), v);
    chk("ps_rerst", v, 64'h2);
    print_verdict();
  end
endmodule
